// ==== core/sio_consts.svh ====
// register offsets, field positions and reset values of the serial channel
`ifndef SIO_CONSTS_SVH
`define SIO_CONSTS_SVH

`define OFS_TX_RX_BUFFER 8'h00
`define OFS_SERIAL_CONTROL_STATUS 8'h04
`define OFS_MODE_CONTROL_0 8'h08
`define OFS_MODE_CONTROL_2 8'h0c
`define OFS_BAUD_DIVIDER_CONTROL 8'h10
`define OFS_BAUD_FRACTION_CONTROL 8'h14

// mode_control_0 fields
`define M0_CLK_SEL_LSB 0
`define M0_FRAME_LSB 2
`define M0_WAKEUP 4
`define M0_RX_ENABLE 5
// serial_control_status fields
`define CS_EDGE_SEL 0
`define CS_CLK_DIR 1
`define CS_OVERRUN 2
`define CS_PARITY_UNDERRUN 3
`define CS_FRAMING 4
`define CS_PARITY_EN 5
`define CS_EVEN 6
`define CS_NINTH 7
// mode_control_2 fields
`define M2_DOUBLE_BUF 0
`define M2_STOP_LEN 1
`define M2_RX_FULL 6
`define M2_TX_EMPTY 7
// baud_divider_control fields
`define BD_N_LSB 0
`define BD_INPUT_LSB 4
`define BD_FRAC_EN 6
// baud_fraction_control fields
`define BF_K_LSB 0

// uart_clock_select codes
`define CLK_TIMER 2'h0
`define CLK_BRG 2'h1
`define CLK_SYS 2'h2
`define CLK_PIN 2'h3

// receive counter sample points (zero based: 7th, 8th, 9th pulse)
`define SAMPLE_FIRST 4'h6
`define SAMPLE_MID 4'h7
`define SAMPLE_LAST 4'h8
`define SYNC_LAST_BIT 4'h7
`define FRAC_BASE 5'h10

`define RST_CLK_SEL 2'h0
`define RST_BRG_N 4'h0
`define RST_BRG_K 4'h1

`endif

// ==== core/sio_pkg.sv ====
// types shared by the serial channel core
package sio_pkg;

	typedef struct packed {
		logic [7:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} bus_req_t;

	typedef enum logic [1:0] {
		FRAME_SYNC = 2'b00,
		FRAME_UART7 = 2'b01,
		FRAME_UART8 = 2'b10,
		FRAME_UART9 = 2'b11
	} frame_mode_t;

	typedef enum logic [1:0] {
		RX_IDLE = 2'b00,
		RX_START = 2'b01,
		RX_DATA = 2'b10,
		RX_STOP = 2'b11
	} rx_state_t;

	typedef struct packed {
		logic [8:0] data;
		logic parity_bad;
		logic framing_bad;
	} rx_frame_t;

endpackage : sio_pkg

// ==== core/serial_channel_clock_and_receive.sv ====
// serial channel: transfer clock generation, buffers, flags and receive path
`timescale 1ns/1ps
`default_nettype none
`include "sio_consts.svh"

// Overview of operation
// [RULE1] 7-bit prescaler, runs only with generator selected
// [RULE2] generator input picks prescaler tap 2/8/32/128
// [RULE3] generator divides by N, or N+(16-K)/16 in uart
// [RULE4] software uses N=1 only with double buffering
// [RULE5] uart clock: timer, generator, system, pin
// [RULE6] uart counters divide serial clock by sixteen
// [RULE7] external shift clock slower than 6/8 system clocks
// [RULE8] receive forced double-buffered in uart and pin clock
// [RULE9] buffer-full set on move, cleared by read
// [RULE10] tx-empty set on load, cleared by write
// [RULE11] control read clears all three error flags
// [RULE12] overrun keeps buffer, drops shift register
// [RULE13] uart parity mismatch sets parity flag
// [RULE14] pin clock after empty shifter sets underrun
// [RULE15] output clock stopped after data sets underrun
// [RULE16] stop bit zero sets framing; never in sync
// [RULE17] 16 pulses per bit, majority of 7/8/9
// [RULE18] sync sampling edge follows clock direction bits
// [RULE19] complete frame raises interrupt, fills buffer
// [RULE20] output clock stops on full, resumes on read
// [RULE21] ninth bit field gets parity or data msb
// [RULE22] wake-up: interrupt only when ninth bit set
// [RULE23] software avoids N of 1 or 16 fractionally
// [RULE24] fractional output is input over N+(16-K)/16
module serial_channel_clock_and_receive #(
	parameter int unsigned PRE_WIDTH = 7
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire sio_pkg::bus_req_t bus_req,
	output logic [31:0] bus_rdata,
	input wire logic serial_rx_pin,
	input wire logic shift_clock_pin_in,
	output logic shift_clock_pin_out,
	output logic shift_clock_pin_oe,
	input wire logic timer_out,
	input wire logic tx_load,
	input wire logic tx_shift_empty,
	input wire logic tx_clock_stopped,
	output logic [8:0] tx_data,
	output logic tx_data_valid,
	output logic rx_interrupt
);
	import sio_pkg::*;

	// configuration
	logic [1:0] clk_sel_ff;
	frame_mode_t frame_mode_ff;
	logic wakeup_enable_ff;
	logic rx_enable_ff;
	logic edge_select_ff;
	logic clock_direction_ff;
	logic parity_enable_ff;
	logic even_parity_ff;
	logic double_buffer_enable_ff;
	logic stop_length_ff;
	logic [3:0] brg_n_ff;
	logic [1:0] baud_input_select_ff;
	logic frac_enable_ff;
	logic [3:0] brg_k_ff;

	// status
	logic overrun_ff;
	logic parity_underrun_ff;
	logic framing_ff;
	logic rx_ninth_bit_ff;
	logic rx_buffer_full_ff;
	logic tx_buffer_empty_ff;
	logic [7:0] rx_buffer_ff;
	logic hold_ff;
	rx_frame_t hold_frame_ff;

	logic is_sync;
	logic is_uart;
	logic clk_out_mode;
	logic rx_double;
	assign is_sync = (frame_mode_ff == FRAME_SYNC);
	assign is_uart = !is_sync;
	assign clk_out_mode = is_sync && !clock_direction_ff;
	assign rx_double = double_buffer_enable_ff || is_uart || clock_direction_ff; // [RULE8]

	logic wr_buf, wr_cs, wr_m0, wr_m2, wr_bd, wr_bf;
	logic rd_buf, rd_cs, rd_m2;
	assign wr_buf = bus_req.wr && (bus_req.addr == `OFS_TX_RX_BUFFER);
	assign wr_cs = bus_req.wr && (bus_req.addr == `OFS_SERIAL_CONTROL_STATUS);
	assign wr_m0 = bus_req.wr && (bus_req.addr == `OFS_MODE_CONTROL_0);
	assign wr_m2 = bus_req.wr && (bus_req.addr == `OFS_MODE_CONTROL_2);
	assign wr_bd = bus_req.wr && (bus_req.addr == `OFS_BAUD_DIVIDER_CONTROL);
	assign wr_bf = bus_req.wr && (bus_req.addr == `OFS_BAUD_FRACTION_CONTROL);
	assign rd_buf = bus_req.rd && (bus_req.addr == `OFS_TX_RX_BUFFER);
	assign rd_cs = bus_req.rd && (bus_req.addr == `OFS_SERIAL_CONTROL_STATUS);
	assign rd_m2 = bus_req.rd && (bus_req.addr == `OFS_MODE_CONTROL_2);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			clk_sel_ff <= `RST_CLK_SEL;
			frame_mode_ff <= FRAME_SYNC;
			wakeup_enable_ff <= 1'b0;
			rx_enable_ff <= 1'b0;
			edge_select_ff <= 1'b0;
			clock_direction_ff <= 1'b0;
			parity_enable_ff <= 1'b0;
			even_parity_ff <= 1'b0;
			double_buffer_enable_ff <= 1'b0;
			stop_length_ff <= 1'b0;
			brg_n_ff <= `RST_BRG_N;
			baud_input_select_ff <= 2'h0;
			frac_enable_ff <= 1'b0;
			brg_k_ff <= `RST_BRG_K;
		end else begin
			if (wr_m0) begin
				clk_sel_ff <= bus_req.wdata[`M0_CLK_SEL_LSB +: 2];
				frame_mode_ff <= frame_mode_t'(bus_req.wdata[`M0_FRAME_LSB +: 2]);
				wakeup_enable_ff <= bus_req.wdata[`M0_WAKEUP];
				rx_enable_ff <= bus_req.wdata[`M0_RX_ENABLE];
			end
			if (wr_cs) begin
				edge_select_ff <= bus_req.wdata[`CS_EDGE_SEL];
				clock_direction_ff <= bus_req.wdata[`CS_CLK_DIR];
				parity_enable_ff <= bus_req.wdata[`CS_PARITY_EN];
				even_parity_ff <= bus_req.wdata[`CS_EVEN];
			end
			if (wr_m2) begin
				double_buffer_enable_ff <= bus_req.wdata[`M2_DOUBLE_BUF];
				stop_length_ff <= bus_req.wdata[`M2_STOP_LEN];
			end
			if (wr_bd) begin
				brg_n_ff <= bus_req.wdata[`BD_N_LSB +: 4];
				baud_input_select_ff <= bus_req.wdata[`BD_INPUT_LSB +: 2];
				frac_enable_ff <= bus_req.wdata[`BD_FRAC_EN];
			end
			if (wr_bf)
				brg_k_ff <= bus_req.wdata[`BF_K_LSB +: 4];
		end
	end

	// prescaler: taps fire once every 2, 8, 32 and 128 clocks
	logic [PRE_WIDTH-1:0] pre_cnt_ff;
	logic pre_run;
	logic [3:0] pre_tick;
	assign pre_run = (clk_sel_ff == `CLK_BRG); // [RULE1]

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			pre_cnt_ff <= '0;
		else if (pre_run)
			pre_cnt_ff <= pre_cnt_ff + 1'b1; // [RULE1]
		else
			pre_cnt_ff <= '0;
	end

	for (genvar i = 0; i < 4; i++) begin : g_tap
		assign pre_tick[i] = pre_run && (&pre_cnt_ff[2*i:0]);
	end

	// baud rate generator; the fraction is spread by an accumulator so the
	// mean period is N+(16-K)/16 without a 1/16-rate master clock
	logic brg_in;
	logic brg_tick;
	logic [4:0] brg_cnt_ff;
	logic [3:0] brg_acc_ff;
	logic brg_extra_ff;
	logic frac_active;
	logic [4:0] brg_period;
	logic [4:0] brg_cnt_nxt;
	logic [4:0] acc_sum;
	assign brg_in = pre_tick[baud_input_select_ff]; // [RULE2]
	assign frac_active = frac_enable_ff && is_uart; // [RULE3]
	assign brg_period = ((brg_n_ff == 4'h0) ? `FRAC_BASE : {1'b0, brg_n_ff})
		+ {4'h0, frac_active && brg_extra_ff};
	assign brg_cnt_nxt = brg_cnt_ff + 5'h01;
	assign brg_tick = brg_in && (brg_cnt_nxt == brg_period); // [RULE3]
	assign acc_sum = {1'b0, brg_acc_ff} + (`FRAC_BASE - {1'b0, brg_k_ff});

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			brg_cnt_ff <= 5'h00;
			brg_acc_ff <= 4'h0;
			brg_extra_ff <= 1'b0;
		end else if (brg_tick) begin
			brg_cnt_ff <= 5'h00;
			brg_acc_ff <= acc_sum[3:0]; // [RULE24]
			brg_extra_ff <= acc_sum[4]; // [RULE24]
		end else if (brg_in) begin
			brg_cnt_ff <= brg_cnt_nxt;
		end
	end

	// edge detection on timer output and shift clock pin
	logic timer_prev_ff;
	logic pin_prev_ff;
	logic timer_rise, pin_rise, pin_fall;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			timer_prev_ff <= 1'b0;
			// pin idles high; a low reset value would fake a rising edge
			pin_prev_ff <= 1'b1;
		end else begin
			timer_prev_ff <= timer_out;
			pin_prev_ff <= shift_clock_pin_in;
		end
	end
	assign timer_rise = timer_out && !timer_prev_ff;
	assign pin_rise = shift_clock_pin_in && !pin_prev_ff;
	assign pin_fall = !shift_clock_pin_in && pin_prev_ff;

	logic serial_bit_clock;
	always_comb begin
		unique case (clk_sel_ff) // [RULE5]
			`CLK_TIMER: serial_bit_clock = timer_rise;
			`CLK_BRG: serial_bit_clock = brg_tick;
			`CLK_SYS: serial_bit_clock = 1'b1;
			`CLK_PIN: serial_bit_clock = pin_rise;
		endcase
	end

	// uart receiver
	rx_state_t rx_state_ff;
	logic [3:0] rx_cnt_ff;
	logic [3:0] bit_idx_ff;
	logic [2:0] samples_ff;
	logic [8:0] shift_ff;
	logic [3:0] frame_bits;
	logic vote;
	logic uart_done;
	logic uart_stop_bad;
	logic sync_done;
	logic [2:0] votes;
	assign votes = {serial_rx_pin, samples_ff[1:0]};
	assign vote = (votes[0] & votes[1]) | (votes[0] & votes[2]) | (votes[1] & votes[2]); // [RULE17]

	always_comb begin
		unique case (frame_mode_ff)
			FRAME_UART7: frame_bits = 4'h7 + {3'h0, parity_enable_ff};
			FRAME_UART8: frame_bits = 4'h8 + {3'h0, parity_enable_ff};
			FRAME_UART9: frame_bits = 4'h9;
			FRAME_SYNC: frame_bits = 4'h8;
		endcase
	end

	logic uart_decide;
	assign uart_decide = serial_bit_clock && (rx_cnt_ff == `SAMPLE_LAST);
	assign uart_done = is_uart && uart_decide && (rx_state_ff == RX_STOP);
	assign uart_stop_bad = !vote; // [RULE16]

	// sync sampling edge
	logic sclk_out_ff;
	logic sclk_toggle;
	logic sync_sample;
	assign sync_sample = clock_direction_ff
		? (edge_select_ff ? pin_fall : pin_rise)
		: (sclk_toggle && !sclk_out_ff); // [RULE18]
	assign sync_done = is_sync && rx_enable_ff && sync_sample
		&& (bit_idx_ff == `SYNC_LAST_BIT);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_state_ff <= RX_IDLE;
			rx_cnt_ff <= 4'h0;
			bit_idx_ff <= 4'h0;
			samples_ff <= 3'h0;
			shift_ff <= 9'h000;
		end else if (!rx_enable_ff) begin
			rx_state_ff <= RX_IDLE;
			rx_cnt_ff <= 4'h0;
			bit_idx_ff <= 4'h0;
		end else if (is_sync) begin
			rx_state_ff <= RX_IDLE;
			if (sync_sample) begin
				shift_ff[bit_idx_ff] <= serial_rx_pin; // [RULE18]
				bit_idx_ff <= (bit_idx_ff == `SYNC_LAST_BIT) ? 4'h0 : bit_idx_ff + 4'h1;
			end
		end else if (serial_bit_clock) begin
			rx_cnt_ff <= rx_cnt_ff + 4'h1; // [RULE6] [RULE17]
			if (rx_cnt_ff == `SAMPLE_FIRST || rx_cnt_ff == `SAMPLE_MID)
				samples_ff <= {samples_ff[1:0], serial_rx_pin}; // [RULE17]
			unique case (rx_state_ff)
				RX_IDLE: begin
					rx_cnt_ff <= 4'h1;
					if (serial_rx_pin)
						rx_cnt_ff <= 4'h0;
					else
						rx_state_ff <= RX_START;
				end
				RX_START: begin
					if (uart_decide) begin
						// a glitch that fails the vote is not a start bit
						rx_state_ff <= vote ? RX_IDLE : RX_DATA;
						bit_idx_ff <= 4'h0;
						shift_ff <= 9'h000;
					end
				end
				RX_DATA: begin
					if (uart_decide) begin
						shift_ff[bit_idx_ff] <= vote; // [RULE17]
						bit_idx_ff <= bit_idx_ff + 4'h1;
						if (bit_idx_ff + 4'h1 == frame_bits)
							rx_state_ff <= RX_STOP;
					end
				end
				RX_STOP: begin
					// one stop bit is checked whatever the transmit stop length
					if (uart_decide) begin
						rx_state_ff <= RX_IDLE; // [RULE16]
						rx_cnt_ff <= 4'h0;
					end
				end
			endcase
		end
	end

	// frame assembly and checks
	rx_frame_t new_frame;
	logic [8:0] sync_data;
	logic expected_parity;
	logic received_parity;
	assign sync_data = {1'b0, serial_rx_pin, shift_ff[6:0]};
	always_comb begin
		new_frame.data = is_sync ? sync_data : shift_ff;
		if (frame_mode_ff == FRAME_UART7) begin
			expected_parity = ^shift_ff[6:0];
			received_parity = shift_ff[7];
		end else begin
			expected_parity = ^shift_ff[7:0];
			received_parity = shift_ff[8];
		end
		new_frame.parity_bad = parity_enable_ff && (frame_mode_ff != FRAME_UART9)
			&& is_uart && ((expected_parity ^ !even_parity_ff) != received_parity); // [RULE13]
		new_frame.framing_bad = is_uart && uart_stop_bad; // [RULE16]
	end

	logic frame_done;
	logic clr_full;
	logic buffer_free;
	logic move_new;
	logic move_hold;
	logic overrun_set;
	logic hold_set;
	rx_frame_t moved;
	assign frame_done = uart_done || sync_done; // [RULE19]
	assign clr_full = rd_buf || rd_m2; // [RULE9]
	assign buffer_free = !rx_buffer_full_ff || clr_full;
	assign move_hold = hold_ff && clr_full; // [RULE20]
	assign move_new = frame_done && buffer_free && !hold_ff;
	assign hold_set = frame_done && !buffer_free && clk_out_mode && rx_double; // [RULE20]
	assign overrun_set = frame_done && !buffer_free && !hold_set; // [RULE12]
	assign moved = move_hold ? hold_frame_ff : new_frame;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_buffer_ff <= 8'h00;
			rx_ninth_bit_ff <= 1'b0;
			rx_buffer_full_ff <= 1'b0;
			hold_ff <= 1'b0;
			hold_frame_ff <= '0;
			rx_interrupt <= 1'b0;
		end else begin
			rx_interrupt <= 1'b0;
			// a move in the same cycle as the read keeps the flag set
			if (move_new || move_hold) begin
				rx_buffer_ff <= moved.data[7:0]; // [RULE19] [RULE12]
				if (is_uart)
					rx_ninth_bit_ff <= moved.data[8]; // [RULE21]
				rx_buffer_full_ff <= 1'b1; // [RULE9]
				rx_interrupt <= !(frame_mode_ff == FRAME_UART9 && wakeup_enable_ff
					&& !moved.data[8]); // [RULE19] [RULE22]
			end else if (clr_full) begin
				rx_buffer_full_ff <= 1'b0; // [RULE9]
			end
			if (hold_set) begin
				hold_ff <= 1'b1;
				hold_frame_ff <= new_frame;
			end else if (move_hold) begin
				hold_ff <= 1'b0;
			end
		end
	end

	// shift clock output: stops at the high level between frames
	logic sclk_stop;
	assign sclk_stop = rx_double ? hold_ff : rx_buffer_full_ff; // [RULE20]
	assign sclk_toggle = clk_out_mode && rx_enable_ff && brg_tick
		&& (!sclk_out_ff || !sclk_stop);
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			sclk_out_ff <= 1'b1;
		else if (!clk_out_mode)
			sclk_out_ff <= 1'b1;
		else if (sclk_toggle)
			sclk_out_ff <= !sclk_out_ff; // [RULE20]
	end
	assign shift_clock_pin_out = sclk_out_ff;
	assign shift_clock_pin_oe = clk_out_mode;

	// error flags: a new event beats the read that clears
	logic underrun_set;
	logic parity_underrun_flag_set;
	assign underrun_set = is_sync && double_buffer_enable_ff && (clock_direction_ff
		? (tx_shift_empty && tx_buffer_empty_ff
			&& (edge_select_ff ? pin_fall : pin_rise)) // [RULE14]
		: tx_clock_stopped); // [RULE15]
	assign parity_underrun_flag_set = underrun_set || ((move_new || move_hold) && moved.parity_bad);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			overrun_ff <= 1'b0;
			parity_underrun_ff <= 1'b0;
			framing_ff <= 1'b0;
		end else begin
			overrun_ff <= (overrun_ff && !rd_cs) || overrun_set; // [RULE11] [RULE12]
			parity_underrun_ff <= (parity_underrun_ff && !rd_cs) || parity_underrun_flag_set; // [RULE11]
			framing_ff <= (framing_ff && !rd_cs)
				|| ((move_new || move_hold) && moved.framing_bad); // [RULE11] [RULE16]
		end
	end

	// transmit buffer; a write beats a load since it brings newer data
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_data <= 9'h000;
			tx_buffer_empty_ff <= 1'b1;
		end else if (wr_buf) begin
			tx_data <= bus_req.wdata[8:0];
			tx_buffer_empty_ff <= 1'b0; // [RULE10]
		end else if (tx_load) begin
			tx_buffer_empty_ff <= 1'b1; // [RULE10]
		end
	end
	assign tx_data_valid = !tx_buffer_empty_ff;

	// read data
	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h0000_0000;
		unique case (bus_req.addr)
			`OFS_TX_RX_BUFFER: rd_mux[7:0] = rx_buffer_ff;
			`OFS_SERIAL_CONTROL_STATUS: begin
				rd_mux[`CS_EDGE_SEL] = edge_select_ff;
				rd_mux[`CS_CLK_DIR] = clock_direction_ff;
				rd_mux[`CS_OVERRUN] = overrun_ff;
				rd_mux[`CS_PARITY_UNDERRUN] = parity_underrun_ff;
				rd_mux[`CS_FRAMING] = framing_ff;
				rd_mux[`CS_PARITY_EN] = parity_enable_ff;
				rd_mux[`CS_EVEN] = even_parity_ff;
				rd_mux[`CS_NINTH] = rx_ninth_bit_ff;
			end
			`OFS_MODE_CONTROL_0: begin
				rd_mux[`M0_CLK_SEL_LSB +: 2] = clk_sel_ff;
				rd_mux[`M0_FRAME_LSB +: 2] = frame_mode_ff;
				rd_mux[`M0_WAKEUP] = wakeup_enable_ff;
				rd_mux[`M0_RX_ENABLE] = rx_enable_ff;
			end
			`OFS_MODE_CONTROL_2: begin
				rd_mux[`M2_DOUBLE_BUF] = double_buffer_enable_ff;
				rd_mux[`M2_STOP_LEN] = stop_length_ff;
				rd_mux[`M2_RX_FULL] = rx_buffer_full_ff;
				rd_mux[`M2_TX_EMPTY] = tx_buffer_empty_ff;
			end
			`OFS_BAUD_DIVIDER_CONTROL: begin
				rd_mux[`BD_N_LSB +: 4] = brg_n_ff;
				rd_mux[`BD_INPUT_LSB +: 2] = baud_input_select_ff;
				rd_mux[`BD_FRAC_EN] = frac_enable_ff;
			end
			`OFS_BAUD_FRACTION_CONTROL: rd_mux[`BF_K_LSB +: 4] = brg_k_ff;
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			bus_rdata <= 32'h0000_0000;
		else
			bus_rdata <= bus_req.rd ? rd_mux : 32'h0000_0000;
	end

endmodule : serial_channel_clock_and_receive
`default_nettype wire

// ==== sim/serial_channel_monitor.sv ====
// port-level checker for the serial channel core
`timescale 1ns/1ps
`default_nettype none
module serial_channel_monitor #(
	parameter int unsigned PRE_WIDTH = 7
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire sio_pkg::bus_req_t bus_req,
	input wire logic [31:0] bus_rdata,
	input wire logic tx_load,
	input wire logic [8:0] tx_data,
	input wire logic tx_data_valid,
	input wire logic rx_interrupt
);
	import sio_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	logic w0;
	logic r04;
	logic r0c;
	assign w0 = bus_req.wr && bus_req.addr == 8'h00;
	assign r04 = bus_req.rd && bus_req.addr == 8'h04;
	assign r0c = bus_req.rd && bus_req.addr == 8'h0c;
	property p_tx_write;
		w0 |=> tx_data_valid && tx_data == $past(bus_req.wdata[8:0]);
	endproperty
	a_tx_write: assert property (p_tx_write) else $error("tx buffer write lost");
	property p_tx_load;
		tx_load && !w0 |=> !tx_data_valid;
	endproperty
	a_tx_load: assert property (p_tx_load) else $error("tx buffer not emptied");
	property p_tx_hold;
		!w0 && !tx_load |=> $stable(tx_data_valid) && $stable(tx_data);
	endproperty
	a_tx_hold: assert property (p_tx_hold) else $error("tx buffer changed unasked");
	property p_empty_bit;
		r0c |=> bus_rdata[7] == !$past(tx_data_valid);
	endproperty
	a_empty_bit: assert property (p_empty_bit) else $error("empty flag read wrong");
	property p_full_clr;
		r0c ##1 (r0c && !rx_interrupt) |=> !bus_rdata[6];
	endproperty
	a_full_clr: assert property (p_full_clr) else $error("full flag kept after read");
	property p_err_clr;
		r04 ##1 (r04 && !rx_interrupt) |=> bus_rdata[4:2] == 3'h0;
	endproperty
	a_err_clr: assert property (p_err_clr) else $error("error flags kept after read");
	property p_irq_pulse;
		rx_interrupt |=> !rx_interrupt [*8];
	endproperty
	a_irq_pulse: assert property (p_irq_pulse) else $error("receive interrupt too long");
	property p_rdata_idle;
		!$past(bus_req.rd) |-> bus_rdata == 32'h0;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read");
	c_irq: cover property (rx_interrupt);
	c_err_rd: cover property (r04 ##1 r04);
	c_load: cover property (tx_load && tx_data_valid);
endmodule : serial_channel_monitor
bind serial_channel_clock_and_receive serial_channel_monitor #(.PRE_WIDTH(PRE_WIDTH)) mon_u (
	.clk(clk), .rst_n(rst_n), .bus_req(bus_req), .bus_rdata(bus_rdata), .tx_load(tx_load),
	.tx_data(tx_data), .tx_data_valid(tx_data_valid), .rx_interrupt(rx_interrupt));
`default_nettype wire

// ==== sim/remote_serial_model.sv ====
// behavioural remote serial device on the receive line and shift clock pin
`timescale 1ns/1ps
`default_nettype none
module remote_serial_model (
	input wire logic clk,
	input wire logic sclk,
	output logic rx,
	output logic sclk_drv,
	output logic sclk_en
);
	logic [7:0] sh;
	logic q;
	logic syn;
	initial begin
		rx = 1'b1;
		sclk_drv = 1'b1;
		sclk_en = 1'b0;
		syn = 1'b0;
		sh = '0;
		q = 1'b1;
	end
	// start low, data lsb first, one stop bit, idle high; gl upsets one sample of each data and stop bit
	task automatic uart(input logic [9:0] b, input int n, per, input bit gl, stp);
		logic v;
		for (int i = -1; i <= n; i++) begin
			for (int j = 0; j < per; j++) begin
				v = (i < 0) ? 1'b0 : (i == n) ? stp : b[i];
				@(posedge clk);
				rx <= (gl && j == 7 && i >= 0) ? ~v : v;
			end
		end
		@(posedge clk);
		rx <= 1'b1;
	endtask : uart
	// period of 16 system clocks, above both minimum periods
	task automatic ext(input logic [7:0] b);
		@(posedge clk);
		sclk_en <= 1'b1;
		for (int i = 0; i < 8; i++) begin
			@(posedge clk);
			sclk_drv <= 1'b0;
			rx <= b[i];
			repeat (8) @(posedge clk);
			sclk_drv <= 1'b1;
			repeat (7) @(posedge clk);
		end
		@(posedge clk);
		sclk_en <= 1'b0;
		rx <= ~b[7];
	endtask : ext
	task automatic load(input logic [7:0] b);
		@(posedge clk);
		rx <= b[0];
		sh <= b;
		syn <= 1'b1;
	endtask : load
	// next bit leaves on each falling pin edge; spent bits come back inverted
	always @(posedge clk) begin
		q <= sclk;
		if (syn && q && !sclk) begin
			rx <= sh[0];
			sh <= {~sh[0], sh[7:1]};
		end
	end
endmodule : remote_serial_model
`default_nettype wire

// ==== sim/serial_channel_clock_and_receive_tb.sv ====
// self-checking bench for the serial channel core
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin err_total++; \
	$display("Error %0t: got %h expected %h", $time, a, e); end end
module serial_channel_clock_and_receive_tb;
	import sio_pkg::*;
	typedef struct {logic [7:0] m0, cr; logic [9:0] b; int n, per; bit gl, stp;
		logic [7:0] eb, ecr, msk;} row_t;
	logic clk, rst_n, rx, sout, soe, pdrv, pen, pin, timer_out, tx_load, tx_shift_empty;
	logic tx_clock_stopped, tx_data_valid, rx_interrupt, q;
	bus_req_t bus_req;
	logic [31:0] bus_rdata, d;
	logic [8:0] tx_data;
	int err_total, checked, c;
	bit got;
	row_t rows[8] = '{'{8'h2a, 8'h00, 10'h0a5, 8, 16, 1, 1, 8'ha5, 8'h00, 8'h1c},
		'{8'h2a, 8'h60, 10'h003, 9, 16, 0, 1, 8'h03, 8'h00, 8'h9c},
		'{8'h2a, 8'h60, 10'h103, 9, 16, 0, 1, 8'h03, 8'h88, 8'h9c},
		'{8'h26, 8'h20, 10'h0d5, 8, 16, 0, 1, 8'hd5, 8'h00, 8'h1c},
		'{8'h2e, 8'h00, 10'h1c3, 9, 16, 0, 1, 8'hc3, 8'h80, 8'h9c},
		'{8'h2a, 8'h00, 10'h05a, 8, 16, 0, 0, 8'h5a, 8'h10, 8'h1c},
		'{8'h28, 8'h00, 10'h0c3, 8, 32, 0, 1, 8'hc3, 8'h00, 8'h1c},
		'{8'h29, 8'h00, 10'h03c, 8, 80, 0, 1, 8'h3c, 8'h00, 8'h1c}};
	// shift clock pin idles high through its pull-up when nobody drives it
	assign pin = soe ? sout : (pen ? pdrv : 1'b1);
	serial_channel_clock_and_receive #(.PRE_WIDTH(7)) dut_u (.clk(clk), .rst_n(rst_n),
		.bus_req(bus_req), .bus_rdata(bus_rdata), .serial_rx_pin(rx), .shift_clock_pin_in(pin),
		.shift_clock_pin_out(sout), .shift_clock_pin_oe(soe), .timer_out(timer_out),
		.tx_load(tx_load), .tx_shift_empty(tx_shift_empty), .tx_clock_stopped(tx_clock_stopped),
		.tx_data(tx_data), .tx_data_valid(tx_data_valid), .rx_interrupt(rx_interrupt));
	remote_serial_model partner_u (.clk(clk), .sclk(pin), .rx(rx), .sclk_drv(pdrv), .sclk_en(pen));
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	always @(posedge clk) timer_out <= ~timer_out;
	task automatic conclude();
		$display("checks %0d errors %0d", checked, err_total);
		if (err_total == 0 && checked > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : conclude
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		bus_req <= '{a, v, 1'b1, 1'b0};
		@(posedge clk);
		bus_req.wr <= 1'b0;
		#1;
	endtask : wr
	// two: a second read of the same place right behind the first
	task automatic rd(input logic [7:0] a, input bit two = 0);
		@(posedge clk);
		bus_req <= '{a, 32'h0, 1'b0, 1'b1};
		if (two) @(posedge clk);
		@(posedge clk);
		bus_req.rd <= 1'b0;
		#1 d = bus_rdata;
	endtask : rd
	task automatic wirq(input int lim);
		got = 0;
		for (int i = 0; i < lim && !got; i++) begin
			@(negedge clk);
			got = rx_interrupt;
		end
	endtask : wirq
	task automatic ufr(input logic [9:0] b, input int n, per, input bit gl, stp);
		fork
			partner_u.uart(b, n, per, gl, stp);
			wirq(per * 11);
		join
	endtask : ufr
	// cycles to the next rising edge of the output shift clock, 2000 if none
	task automatic rise();
		c = 0;
		do begin
			q = sout;
			@(negedge clk);
			c++;
		end while (!(sout && !q) && c < 2000);
	endtask : rise
	initial begin
		#400000;
		err_total++;
		conclude();
	end
	initial begin
		rst_n = 1'b0;
		bus_req = '0;
		timer_out = 1'b0;
		tx_load = 1'b0;
		tx_shift_empty = 1'b1;
		tx_clock_stopped = 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		rd(8'h0c); `CHK(d, 32'h80)
		rd(8'h14); `CHK(d, 32'h1)
		wr(8'h3c, 32'hff);
		rd(8'h3c); `CHK(d, 32'h0)
		wr(8'h10, 32'h42);
		wr(8'h14, 32'h8);
		foreach (rows[i]) begin
			wr(8'h04, rows[i].cr);
			wr(8'h08, rows[i].m0);
			ufr(rows[i].b, rows[i].n, rows[i].per, rows[i].gl, rows[i].stp);
			`CHK(got, 1'b1)
			rd(8'h00); `CHK(d[7:0], rows[i].eb)
			rd(8'h04); `CHK(d[7:0] & rows[i].msk, rows[i].ecr)
		end
		wr(8'h00, 32'h1ab); `CHK(tx_data, 9'h1ab)
		rd(8'h0c); `CHK(d[7], 1'b0)
		@(posedge clk) tx_load <= 1'b1;
		@(posedge clk) tx_load <= 1'b0;
		rd(8'h0c); `CHK(d[7], 1'b1)
		wr(8'h04, 32'h0);
		wr(8'h08, 32'h2a);
		ufr(10'h011, 8, 16, 0, 1);
		ufr(10'h022, 8, 16, 0, 1); `CHK(got, 1'b0)
		rd(8'h04); `CHK(d[2], 1'b1)
		rd(8'h00); `CHK(d[7:0], 8'h11)
		ufr(10'h033, 8, 16, 0, 1);
		rd(8'h0c); `CHK(d[6], 1'b1)
		rd(8'h0c, 1); `CHK(d[6], 1'b0)
		ufr(10'h000, 8, 16, 0, 0);
		rd(8'h00);
		rd(8'h04, 1); `CHK(d[4:2], 3'h0)
		wr(8'h08, 32'h3e);
		ufr(10'h055, 9, 16, 0, 1); `CHK(got, 1'b0)
		rd(8'h00);
		ufr(10'h155, 9, 16, 0, 1); `CHK(got, 1'b1)
		rd(8'h00);
		wr(8'h08, 32'h0);
		wr(8'h0c, 32'h1);
		@(posedge clk) tx_clock_stopped <= 1'b1;
		@(posedge clk) tx_clock_stopped <= 1'b0;
		rd(8'h04); `CHK(d[3], 1'b1)
		wr(8'h04, 32'h2);
		wr(8'h08, 32'h20);
		`CHK(soe, 1'b0)
		fork
			partner_u.ext(8'h96);
			wirq(400);
		join
		`CHK(got, 1'b1)
		rd(8'h00); `CHK(d[7:0], 8'h96)
		rd(8'h04); `CHK(d[4:2], 3'b010)
		wr(8'h04, 32'h0);
		wr(8'h0c, 32'h0);
		for (int t = 0; t < 4; t++) begin
			wr(8'h10, 32'(t * 16 + 3));
			partner_u.load(8'h69 + 8'(t));
			wr(8'h08, 32'h21);
			rise();
			rise(); `CHK(c, 6 * (2 << (2 * t)))
			wirq(20000);
			rise(); `CHK(c, 2000)
			rd(8'h00); `CHK(d[7:0], 8'h69 + 8'(t))
			rise(); `CHK(c < 2000, 1'b1)
			wirq(20000);
			// disable first so the read cannot restart the clock and leave it low
			wr(8'h08, 32'h0);
			rd(8'h00);
		end
		@(posedge clk) rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		`CHK(soe, 1'b1)
		rd(8'h10); `CHK(d, 32'h0)
		rd(8'h14); `CHK(d, 32'h1)
		rd(8'h0c); `CHK(d, 32'h80)
		conclude();
	end
endmodule : serial_channel_clock_and_receive_tb
`default_nettype wire
